// [ctl_model.sv]
// Display controller model driving shift clock, serial data and latch strobe.
`timescale 1ns/1ps
`default_nettype none

module ctl_model (
	input  wire logic  clk,
	output logic       sclk,
	output logic       sd,
	output logic       stb
);
	initial begin
		sclk = 1'b0;
		sd = 1'b0;
		stb = 1'b0;
	end
	// The bench routes sd to whichever pin is the input for the direction.
	task automatic send(input logic d, input int slow);
		@(posedge clk);
		sclk <= 1'b1;
		sd <= d;
		repeat (slow) @(posedge clk);
		@(posedge clk);
		sclk <= 1'b0;
		repeat (slow) @(posedge clk);
		@(posedge clk);
		// Past the hold time the line no longer shows the bit.
		sd <= ~d;
	endtask
	task automatic strobe;
		@(posedge clk);
		stb <= 1'b1;
		repeat (4) @(posedge clk);
		stb <= 1'b0;
	endtask
endmodule // ctl_model
`default_nettype wire

// [grid_driver_chk.sv]
// Concurrent checks on the grid driver pins, bound to the top module.
`timescale 1ns/1ps
`default_nettype none
`include "grid_map.vh"

module grid_chk (
	input wire logic                CLK_SYS,
	input wire logic                RST_N,
	input wire logic                CLK_EN,
	input wire logic                SHIFT_CLK,
	input wire logic                CHAIN_CLR_N,
	input wire logic                SHIFT_DIR,
	input wire logic                LATCH_STROBE,
	input wire logic                OUTPUT_BLANK_N,
	input wire logic                SERIAL_A_IN,
	input wire logic                SERIAL_A_OUT,
	input wire logic                SERIAL_A_OE,
	input wire logic                SERIAL_B_IN,
	input wire logic                SERIAL_B_OUT,
	input wire logic                SERIAL_B_OE,
	input wire logic [`GRID_MSB:0]  GRID_DRIVE_OUT
);
	default clocking dc @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	// The control register is assumed at its reset value; the bench never changes it.
	oe_dirs_a: assert property (SERIAL_A_OE == SHIFT_DIR && SERIAL_B_OE == !SHIFT_DIR)
		else $error("Serial enables do not follow the direction.");
	clr_zero_a: assert property (!CHAIN_CLR_N |-> !SERIAL_A_OUT && !SERIAL_B_OUT)
		else $error("Serial outputs not low during chain clear.");
	blank_low_a: assert property (!OUTPUT_BLANK_N && CLK_EN |=> GRID_DRIVE_OUT == `ZERO_GRID)
		else $error("Grid outputs not low while blanked.");
	fwd_entry_a: assert property ($past(SHIFT_CLK) && !SHIFT_CLK && !SHIFT_DIR && CHAIN_CLR_N
		&& CLK_EN |=> !CHAIN_CLR_N || SERIAL_A_OUT == $past(SERIAL_A_IN))
		else $error("Forward shift did not load the first stage.");
	rev_entry_a: assert property ($past(SHIFT_CLK) && !SHIFT_CLK && SHIFT_DIR && CHAIN_CLR_N
		&& CLK_EN |=> !CHAIN_CLR_N || SERIAL_B_OUT == $past(SERIAL_B_IN))
		else $error("Reverse shift did not load the last stage.");
	no_shift_a: assert property (!($past(SHIFT_CLK) && !SHIFT_CLK) && CHAIN_CLR_N
		|=> !CHAIN_CLR_N || ($stable(SERIAL_A_OUT) && $stable(SERIAL_B_OUT)))
		else $error("Chain moved without a falling shift clock.");
	grid_follow_a: assert property ((LATCH_STROBE && OUTPUT_BLANK_N && CHAIN_CLR_N && CLK_EN
		&& $stable(SERIAL_A_OUT) && $stable(SERIAL_B_OUT)) [*3]
		|-> GRID_DRIVE_OUT[0] == SERIAL_A_OUT && GRID_DRIVE_OUT[`GRID_MSB] == SERIAL_B_OUT)
		else $error("Grid end bits do not follow the chain ends.");
	latch_hold_a: assert property ((!LATCH_STROBE && OUTPUT_BLANK_N) [*3]
		|-> $stable(GRID_DRIVE_OUT))
		else $error("Grid changed while the strobe was low.");
endmodule // grid_chk

bind grid_driver_shift_latch grid_chk CHK (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CLK_EN(CLK_EN),
	.SHIFT_CLK(SHIFT_CLK), .CHAIN_CLR_N(CHAIN_CLR_N), .SHIFT_DIR(SHIFT_DIR),
	.LATCH_STROBE(LATCH_STROBE), .OUTPUT_BLANK_N(OUTPUT_BLANK_N), .SERIAL_A_IN(SERIAL_A_IN),
	.SERIAL_A_OUT(SERIAL_A_OUT), .SERIAL_A_OE(SERIAL_A_OE), .SERIAL_B_IN(SERIAL_B_IN),
	.SERIAL_B_OUT(SERIAL_B_OUT), .SERIAL_B_OE(SERIAL_B_OE), .GRID_DRIVE_OUT(GRID_DRIVE_OUT));
`default_nettype wire

// [grid_driver_shift_latch.v]
// Top of the grid driver: pin routing, shift clock edge and register slave.
`timescale 1ns/1ps
`default_nettype none
`include "grid_map.vh"

module grid_driver_shift_latch (
	input  wire                    CLK_SYS,
	input  wire                    RST_N,
	input  wire                    CLK_EN,
	input  wire                    SHIFT_CLK,
	input  wire                    CHAIN_CLR_N,
	input  wire                    SHIFT_DIR,
	input  wire                    LATCH_STROBE,
	input  wire                    OUTPUT_BLANK_N,
	input  wire                    SERIAL_A_IN,
	output wire                    SERIAL_A_OUT,
	output wire                    SERIAL_A_OE,
	input  wire                    SERIAL_B_IN,
	output wire                    SERIAL_B_OUT,
	output wire                    SERIAL_B_OE,
	output wire [`GRID_MSB:0]      GRID_DRIVE_OUT,
	input  wire [`ADDR_W-1:0]      S_AXI_AWADDR,
	input  wire                    S_AXI_AWVALID,
	output wire                    S_AXI_AWREADY,
	input  wire [`DATA_W-1:0]      S_AXI_WDATA,
	input  wire [3:0]              S_AXI_WSTRB,
	input  wire                    S_AXI_WVALID,
	output wire                    S_AXI_WREADY,
	output wire [1:0]              S_AXI_BRESP,
	output wire                    S_AXI_BVALID,
	input  wire                    S_AXI_BREADY,
	input  wire [`ADDR_W-1:0]      S_AXI_ARADDR,
	input  wire                    S_AXI_ARVALID,
	output wire                    S_AXI_ARREADY,
	output wire [`DATA_W-1:0]      S_AXI_RDATA,
	output wire [1:0]              S_AXI_RRESP,
	output wire                    S_AXI_RVALID,
	input  wire                    S_AXI_RREADY
);

	// Pin side state.
	reg                    shift_clk_prev_ff;
	reg  [`CTRL_W-1:0]     ctrl_ff;
	reg  [`DATA_W-1:0]     shift_cnt_ff;

	// Write channel state.
	reg                    aw_held_ff;
	reg  [`ADDR_W-1:0]     aw_addr_ff;
	reg                    w_held_ff;
	reg  [`DATA_W-1:0]     w_data_ff;
	reg  [3:0]             w_strb_ff;
	reg                    bvalid_ff;
	reg  [1:0]             bresp_ff;

	// Read channel state.
	reg                    rvalid_ff;
	reg  [`DATA_W-1:0]     rdata_ff;
	reg  [1:0]             rresp_ff;

	// Combinational helpers.
	wire                   shift_fall;
	wire                   shift_go;
	wire                   chain_clr_n;
	wire                   blank_n;
	wire [`GRID_MSB:0]     stage_q;
	wire [`GRID_MSB:0]     latch_q;
	wire                   aw_take;
	wire                   w_take;
	wire                   aw_have;
	wire                   w_have;
	wire [`ADDR_W-1:0]     wr_addr;
	wire [`DATA_W-1:0]     wr_data;
	wire [3:0]             wr_strb;
	wire                   wr_fire;
	wire                   wr_ctrl;
	wire                   wr_cnt;
	wire                   wr_hit;
	wire                   ar_take;
	reg  [`DATA_W-1:0]     rd_mux;
	reg                    rd_hit;

	// The pins are synchronous to CLK_SYS, so one stage is enough to find the edge.
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			shift_clk_prev_ff <= 1'b0;
		end else if (CLK_EN) begin
			shift_clk_prev_ff <= SHIFT_CLK;
		end
	end

	assign shift_fall = shift_clk_prev_ff & ~SHIFT_CLK;
	assign shift_go   = shift_fall & ctrl_ff[`CTRL_SHIFT_EN];

	// Software can hold the chain cleared as if the clear pin were low.
	assign chain_clr_n = CHAIN_CLR_N & ~ctrl_ff[`CTRL_SOFT_CLR];

	// A floating blank pin resolves low outside; a forced blank overrides it.
	assign blank_n = OUTPUT_BLANK_N & ~ctrl_ff[`CTRL_FORCE_BLANK];

	shift_chain u_chain (
		.clk     (CLK_SYS),
		.rst_n   (RST_N),
		.ce      (CLK_EN),
		.shift   (shift_go),
		.clr_n   (chain_clr_n),
		.dir     (SHIFT_DIR),
		.fwd_in  (SERIAL_A_IN),
		.rev_in  (SERIAL_B_IN),
		.stage_q (stage_q)
	);

	output_latch u_latch (
		.clk     (CLK_SYS),
		.rst_n   (RST_N),
		.ce      (CLK_EN),
		.strobe  (LATCH_STROBE),
		.blank_n (blank_n),
		.din     (stage_q),
		.latch_q (latch_q),
		.grid_q  (GRID_DRIVE_OUT)
	);

	// Pin A drives only in reverse, pin B only in forward.
	assign SERIAL_A_OE  = SHIFT_DIR;
	assign SERIAL_B_OE  = ~SHIFT_DIR;
	assign SERIAL_A_OUT = stage_q[`STAGE_FIRST];
	assign SERIAL_B_OUT = stage_q[`STAGE_LAST];

	// Write address and data are taken in either order and held until both are in.
	assign S_AXI_AWREADY = CLK_EN & ~aw_held_ff & ~bvalid_ff;
	assign S_AXI_WREADY  = CLK_EN & ~w_held_ff & ~bvalid_ff;
	assign aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
	assign w_take  = S_AXI_WVALID & S_AXI_WREADY;
	assign aw_have = aw_held_ff | aw_take;
	assign w_have  = w_held_ff | w_take;
	assign wr_addr = aw_held_ff ? aw_addr_ff : S_AXI_AWADDR;
	assign wr_data = w_held_ff ? w_data_ff : S_AXI_WDATA;
	assign wr_strb = w_held_ff ? w_strb_ff : S_AXI_WSTRB;
	assign wr_fire = CLK_EN & aw_have & w_have & ~bvalid_ff;
	assign wr_ctrl = wr_fire & (wr_addr == `ADR_CTRL);
	assign wr_cnt  = wr_fire & (wr_addr == `ADR_SHIFT_CNT);
	assign wr_hit  = (wr_addr == `ADR_CTRL) | (wr_addr == `ADR_SHIFT_CNT);

	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			aw_held_ff <= 1'b0;
			aw_addr_ff <= {`ADDR_W{1'b0}};
			w_held_ff  <= 1'b0;
			w_data_ff  <= `DATA_ZERO;
			w_strb_ff  <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= `RESP_OKAY;
		end else if (CLK_EN) begin
			if (wr_fire) begin
				aw_held_ff <= 1'b0;
				w_held_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else begin
				if (aw_take) begin
					aw_held_ff <= 1'b1;
					aw_addr_ff <= S_AXI_AWADDR;
				end
				if (w_take) begin
					w_held_ff <= 1'b1;
					w_data_ff <= S_AXI_WDATA;
					w_strb_ff <= S_AXI_WSTRB;
				end
				if (bvalid_ff && S_AXI_BREADY) begin
					bvalid_ff <= 1'b0;
				end
			end
		end
	end

	assign S_AXI_BVALID = bvalid_ff;
	assign S_AXI_BRESP  = bresp_ff;

	// Control register; only the low byte lane carries fields.
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_ff <= `CTRL_RST;
		end else if (CLK_EN && wr_ctrl && wr_strb[0]) begin
			ctrl_ff <= wr_data[`CTRL_W-1:0];
		end
	end

	// Shift counter; a shift in the clearing cycle is kept, so it restarts at one.
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			shift_cnt_ff <= `CNT_ZERO;
		end else if (CLK_EN) begin
			if (wr_cnt) begin
				shift_cnt_ff <= (shift_go && chain_clr_n) ? `CNT_ONE : `CNT_ZERO;
			end else if (shift_go && chain_clr_n) begin
				shift_cnt_ff <= shift_cnt_ff + `CNT_ONE;
			end
		end
	end

	// Read data are captured at the address handshake, so they are one snapshot.
	always @* begin
		rd_mux = `DATA_ZERO;
		rd_hit = 1'b1;
		case (S_AXI_ARADDR)
			`ADR_CTRL: begin
				rd_mux = {{(`DATA_W-`CTRL_W){1'b0}}, ctrl_ff};
			end
			`ADR_STATUS: begin
				rd_mux = {{`STATUS_PAD{1'b0}}, chain_clr_n, blank_n,
					LATCH_STROBE, SHIFT_DIR};
			end
			`ADR_STAGE_LO: begin
				rd_mux = stage_q[`DATA_W-1:0];
			end
			`ADR_STAGE_HI: begin
				rd_mux = {{`HI_PAD{1'b0}}, stage_q[`GRID_MSB:`DATA_W]};
			end
			`ADR_LATCH_LO: begin
				rd_mux = latch_q[`DATA_W-1:0];
			end
			`ADR_LATCH_HI: begin
				rd_mux = {{`HI_PAD{1'b0}}, latch_q[`GRID_MSB:`DATA_W]};
			end
			`ADR_SHIFT_CNT: begin
				rd_mux = shift_cnt_ff;
			end
			default: begin
				rd_mux = `DATA_ZERO;
				rd_hit = 1'b0;
			end
		endcase
	end

	assign S_AXI_ARREADY = CLK_EN & ~rvalid_ff;
	assign ar_take = S_AXI_ARVALID & S_AXI_ARREADY;

	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= `DATA_ZERO;
			rresp_ff  <= `RESP_OKAY;
		end else if (CLK_EN) begin
			if (ar_take) begin
				rvalid_ff <= 1'b1;
				rdata_ff  <= rd_mux;
				rresp_ff  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rvalid_ff && S_AXI_RREADY) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	assign S_AXI_RVALID = rvalid_ff;
	assign S_AXI_RDATA  = rdata_ff;
	assign S_AXI_RRESP  = rresp_ff;

endmodule // grid_driver_shift_latch

`default_nettype wire

// [grid_driver_shift_latch_tb.sv]
// Self-checking bench for the grid driver shift chain and latch.
`timescale 1ns/1ps
`default_nettype none
`include "grid_map.vh"

module grid_driver_shift_latch_tb;
	localparam logic [39:0] PF = 40'hA5_C3F0_1E69;
	localparam logic [39:0] PR = 40'h3C_0FF0_96A5;
	logic                clk, rst_n, dir, clr_n, blank_n, awv, wv, bry, arv, rry;
	logic [7:0]          awa, ara;
	logic [31:0]         wd;
	wire logic           sclk, sd, stb, a_out, a_oe, b_out, b_oe, awr, wr, bv, arr, rv;
	wire logic [1:0]     br, rr;
	wire logic [31:0]    rd;
	wire logic [`GRID_MSB:0] grid;
	wire logic           a_in = a_oe ? a_out : sd;
	wire logic           b_in = b_oe ? b_out : sd;
	int                  bad_count, compares;

	grid_driver_shift_latch DUT (.CLK_SYS(clk), .RST_N(rst_n), .CLK_EN(1'b1), .SHIFT_CLK(sclk),
		.CHAIN_CLR_N(clr_n), .SHIFT_DIR(dir), .LATCH_STROBE(stb), .OUTPUT_BLANK_N(blank_n),
		.SERIAL_A_IN(a_in), .SERIAL_A_OUT(a_out), .SERIAL_A_OE(a_oe), .SERIAL_B_IN(b_in),
		.SERIAL_B_OUT(b_out), .SERIAL_B_OE(b_oe), .GRID_DRIVE_OUT(grid), .S_AXI_AWADDR(awa),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry));
	ctl_model PART (.clk(clk), .sclk(sclk), .sd(sd), .stb(stb));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#40000;
		bad_count++;
		$display("MISMATCH %0t watchdog expired", $time);
		give_verdict;
	end

	task automatic give_verdict;
		if (bad_count == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [39:0] g, input logic [39:0] e, input string m);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (!bv);
		chk(40'(br), 40'(er), "write resp");
		bry <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		chk(40'(rd), 40'(e), "read data");
		chk(40'(rr), 40'(er), "read resp");
		rry <= 1'b0;
	endtask
	task automatic load(input logic [39:0] v, input logic rev);
		for (int i = 0; i < 40; i++) PART.send(rev ? v[i] : v[39-i], i % 3);
	endtask
	task automatic s_regs;
		@(negedge clk);
		chk(40'({a_out, b_out}), 40'h00_0000_0000, "serial after reset");
		rchk(`ADR_CTRL, 32'(`CTRL_RST), `RESP_OKAY);
		wchk(`ADR_CTRL, 32'h0000_0001, `RESP_OKAY);
		wchk(`ADR_STATUS, `DATA_ZERO, `RESP_SLVERR);
		rchk(8'h1C, `DATA_ZERO, `RESP_SLVERR);
	endtask
	task automatic s_fwd;
		load(PF, 1'b0);
		@(negedge clk);
		chk(40'(b_out), 40'(PF[39]), "forward serial out");
		rchk(`ADR_STAGE_LO, PF[31:0], `RESP_OKAY);
		rchk(`ADR_STAGE_HI, 32'(PF[39:32]), `RESP_OKAY);
		PART.strobe;
		repeat (2) @(negedge clk);
		chk(grid, PF, "grid after forward load");
	endtask
	task automatic s_hold;
		PART.send(1'b0, 0);
		repeat (2) @(negedge clk);
		chk(grid, PF, "grid moved with strobe low");
		@(posedge clk);
		clr_n <= 1'b0;
		@(negedge clk);
		chk(40'({a_out, b_out}), 40'h00_0000_0000, "serial during clear");
		repeat (3) @(negedge clk);
		chk(grid, PF, "grid after chain clear");
		rchk(`ADR_STAGE_LO, `DATA_ZERO, `RESP_OKAY);
		rchk(`ADR_LATCH_LO, PF[31:0], `RESP_OKAY);
		rchk(`ADR_LATCH_HI, 32'(PF[39:32]), `RESP_OKAY);
		@(posedge clk);
		clr_n <= 1'b1;
	endtask
	task automatic s_rev;
		@(posedge clk);
		dir <= 1'b1;
		@(negedge clk);
		chk(40'({a_oe, b_oe}), 40'h00_0000_0002, "enables in reverse");
		load(PR, 1'b1);
		@(negedge clk);
		chk(40'(a_out), 40'(PR[0]), "reverse serial out");
		PART.strobe;
		repeat (2) @(negedge clk);
		chk(grid, PR, "grid after reverse load");
		rchk(`ADR_LATCH_LO, PR[31:0], `RESP_OKAY);
		rchk(`ADR_LATCH_HI, 32'(PR[39:32]), `RESP_OKAY);
		// Forty forward shifts, one while holding, and forty reverse shifts.
		rchk(`ADR_SHIFT_CNT, 32'h0000_0051, `RESP_OKAY);
		wchk(`ADR_SHIFT_CNT, `DATA_ZERO, `RESP_OKAY);
		rchk(`ADR_SHIFT_CNT, `DATA_ZERO, `RESP_OKAY);
	endtask
	task automatic s_blank;
		// An undriven blank pin is pulled down, so it is driven low here.
		@(posedge clk);
		blank_n <= 1'b0;
		repeat (2) @(negedge clk);
		chk(grid, `ZERO_GRID, "grid while blanked");
		// Status shows clear released, blank active, strobe low, reverse direction.
		rchk(`ADR_STATUS, 32'h0000_0009, `RESP_OKAY);
		@(posedge clk);
		blank_n <= 1'b1;
		repeat (2) @(negedge clk);
		chk(grid, PR, "grid after unblank");
	endtask

	initial begin
		{rst_n, dir, blank_n, awv, wv, bry, arv, rry} = 8'h00;
		clr_n = 1'b1;
		{awa, ara, wd} = 48'h0000_0000_0000;
		bad_count = 0;
		compares = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		blank_n <= 1'b1;
		s_regs;
		s_fwd;
		s_hold;
		s_rev;
		s_blank;
		give_verdict;
	end
endmodule // grid_driver_shift_latch_tb
`default_nettype wire

// [grid_map.vh]
// Constants for the grid driver shift register, latch and register block.
`ifndef GRID_MAP_VH
`define GRID_MAP_VH

// Shift chain and latch geometry.
`define GRID_STAGES      40
`define GRID_MSB         39
`define STAGE_FIRST      0
`define STAGE_LAST       39
`define HI_MSB           7
`define HI_PAD           24
`define ZERO_GRID        40'h00_0000_0000

// Register bus geometry and byte addresses.
`define ADDR_W           8
`define DATA_W           32
`define ADR_CTRL         8'h00
`define ADR_STATUS       8'h04
`define ADR_STAGE_LO     8'h08
`define ADR_STAGE_HI     8'h0C
`define ADR_LATCH_LO     8'h10
`define ADR_LATCH_HI     8'h14
`define ADR_SHIFT_CNT    8'h18

// Bus responses.
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

// Control register fields and reset value.
`define CTRL_W           3
`define CTRL_SHIFT_EN    0
`define CTRL_SOFT_CLR    1
`define CTRL_FORCE_BLANK 2
`define CTRL_RST         3'h1

// Status register padding, counter values and the zero data word.
`define STATUS_PAD       28
`define CNT_ZERO         32'h0000_0000
`define CNT_ONE          32'h0000_0001
`define DATA_ZERO        32'h0000_0000

`endif

// [output_latch.v]
// Strobed output latch with blanking and registered grid drive.
`timescale 1ns/1ps
`default_nettype none
`include "grid_map.vh"

module output_latch (
	input  wire                    clk,
	input  wire                    rst_n,
	input  wire                    ce,
	input  wire                    strobe,
	input  wire                    blank_n,
	input  wire [`GRID_MSB:0]      din,
	output wire [`GRID_MSB:0]      latch_q,
	output wire [`GRID_MSB:0]      grid_q
);

	reg  [`GRID_MSB:0] latch_ff;
	reg  [`GRID_MSB:0] grid_ff;
	wire [`GRID_MSB:0] nxt_grid;

	// The latch has no clear of its own, so a chain clear leaves it alone.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_ff <= `ZERO_GRID;
		end else if (ce && strobe) begin
			latch_ff <= din;
		end
	end

	genvar i;
	generate
		for (i = 0; i < `GRID_STAGES; i = i + 1) begin : g_grid
			assign nxt_grid[i] = blank_n & latch_ff[i];
		end
	endgenerate

	// Reset leaves the outputs low, the same as a floating blank input.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			grid_ff <= `ZERO_GRID;
		end else if (ce) begin
			grid_ff <= nxt_grid;
		end
	end

	assign latch_q = latch_ff;
	assign grid_q  = grid_ff;

endmodule // output_latch

`default_nettype wire

// [shift_chain.v]
// Forty stage bidirectional shift chain with clear.
`timescale 1ns/1ps
`default_nettype none
`include "grid_map.vh"

module shift_chain (
	input  wire                    clk,
	input  wire                    rst_n,
	input  wire                    ce,
	input  wire                    shift,
	input  wire                    clr_n,
	input  wire                    dir,
	input  wire                    fwd_in,
	input  wire                    rev_in,
	output wire [`GRID_MSB:0]      stage_q
);

	reg  [`GRID_MSB:0] stage_bit_ff;
	wire [`GRID_MSB:0] nxt_stage_bit;

	genvar i;
	generate
		for (i = 0; i < `GRID_STAGES; i = i + 1) begin : g_stage
			wire from_low;
			wire from_high;
			if (i == `STAGE_FIRST) begin : g_first
				assign from_low = fwd_in;
			end else begin : g_mid_low
				assign from_low = stage_bit_ff[i-1];
			end
			if (i == `STAGE_LAST) begin : g_last
				assign from_high = rev_in;
			end else begin : g_mid_high
				assign from_high = stage_bit_ff[i+1];
			end
			assign nxt_stage_bit[i] = dir ? from_high : from_low;
		end
	endgenerate

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_bit_ff <= `ZERO_GRID;
		end else if (ce) begin
			if (!clr_n) begin
				stage_bit_ff <= `ZERO_GRID;
			end else if (shift) begin
				stage_bit_ff <= nxt_stage_bit;
			end
		end
	end

	// The mask makes a clear visible at once, without waiting for a clock edge.
	assign stage_q = stage_bit_ff & {`GRID_STAGES{clr_n}};

endmodule // shift_chain

`default_nettype wire
